// File: design/brown_out_reset_control.sv
// power-on and brown-out reset sequencer with apb registers
`timescale 1ns/1ps

module brown_out_reset_control
    import bor_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              por_below_min,
    input  wire logic              power_up_timer_busy,
    input  wire logic              external_reset_pin_n,
    input  wire logic              bor_below_threshold,
    input  wire logic              bor_ready,
    input  wire logic              sleep_req,
    input  wire logic              wake_req,
    input  wire logic              bulk_erase_active,
    output logic                   chip_reset,
    output logic                   bor_enable,
    output logic      [1:0]        bor_level,
    output logic                   erase_abort,
    output logic                   in_sleep
);
    typedef enum logic [1:0] {S_RESET, S_RUN, S_SLEEP, S_WAKE} seq_state_t;

    typedef struct packed {
        seq_state_t state;
        logic       chip_reset;
        logic       bor_enable;
        logic [1:0] bor_level;
        logic       erase_abort;
        logic       abort_seen;
        logic       in_sleep;
        logic       bor_reset;
        logic       pready;
    } top_state_t;

    top_state_t st_q;
    top_state_t st_d;

    logic [1:0]        mode;
    logic [1:0]        level_cfg;
    logic              soft_en;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rdata_w;
    logic              err_w;
    logic              det_on;
    logic              supply_ok;
    logic              startup_ok;
    logic              wake_ok;

    bor_filter_if flt ();

    bor_apb_regs u_regs (
        .pclk                   (pclk),
        .presetn                (presetn),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .status_word            (status_word),
        .prdata                 (rdata_w),
        .pslverr                (err_w),
        .brown_out_mode_field   (mode),
        .brown_out_level_select (level_cfg),
        .brown_out_soft_enable  (soft_en)
    );

    bor_dip_filter u_filter (
        .pclk    (pclk),
        .presetn (presetn),
        .flt     (flt)
    );

    // detector enable per mode, state and erase
    function automatic logic det_enable(input logic [1:0] m, input logic sw,
                                        input logic slp, input logic erase);
        logic en;
        en = 1'b0;
        case (m)
            MODE_ALWAYS_ON: en = 1'b1;
            MODE_OFF_SLEEP: en = !slp;
            MODE_SOFTWARE:  en = sw;
            default:        en = 1'b0;
        endcase
        return en | erase;
    endfunction : det_enable

    // only the sleep state itself counts, so the detector is back on while waking
    assign det_on    = det_enable(mode, soft_en, st_q.state == S_SLEEP, bulk_erase_active);
    assign supply_ok = bor_ready && !bor_below_threshold;

    // protection only once the detector is ready
    assign flt.armed = st_q.bor_enable && bor_ready;
    assign flt.below = bor_below_threshold;

    assign startup_ok = (mode == MODE_ALWAYS_ON || mode == MODE_OFF_SLEEP) ? supply_ok : 1'b1;
    assign wake_ok    = (mode == MODE_OFF_SLEEP) ? bor_ready : 1'b1;

    // readable status: ready, active, causes, level
    always_comb
    begin
        status_word                      = '0;
        status_word[ST_READY_BIT]        = bor_ready;
        status_word[ST_ACTIVE_BIT]       = st_q.bor_enable;
        status_word[ST_RESET_BIT]        = st_q.bor_reset;
        status_word[ST_ABORT_BIT]        = st_q.abort_seen;
        status_word[ST_STARTUP_BIT]      = (st_q.state == S_RESET);
        status_word[ST_LEVEL_LSB +: 2]   = st_q.bor_level;
    end

    // sequencer next state
    always_comb
    begin
        st_d             = st_q;
        st_d.bor_enable  = det_on;
        st_d.bor_level   = bulk_erase_active ? LEVEL_ERASE : level_cfg;
        st_d.erase_abort = 1'b0;
        st_d.pready      = psel && !penable;
        if (bulk_erase_active && flt.trip)
        begin
            st_d.erase_abort = 1'b1;
            st_d.abort_seen  = 1'b1;
        end
        case (st_q.state)
            S_RESET:
            begin
                st_d.chip_reset = 1'b1;
                st_d.in_sleep   = 1'b0;
                if (!por_below_min && !power_up_timer_busy && external_reset_pin_n
                    && startup_ok)
                begin
                    st_d.state      = S_RUN;
                    st_d.chip_reset = 1'b0;
                end
            end
            S_RUN:
            begin
                if (sleep_req)
                begin
                    st_d.state    = S_SLEEP;
                    st_d.in_sleep = 1'b1;
                end
            end
            S_SLEEP:
            begin
                if (wake_req)
                    st_d.state = S_WAKE;
            end
            default:
            begin
                if (wake_ok)
                begin
                    st_d.state    = S_RUN;
                    st_d.in_sleep = 1'b0;
                end
            end
        endcase
        if (por_below_min || !external_reset_pin_n)
        begin
            st_d.state      = S_RESET;
            st_d.chip_reset = 1'b1;
            st_d.bor_reset  = 1'b0; // fresh non-brown-out reset cause
        end
        // trip still latched from an erase abort must not reset
        if (flt.trip && !bulk_erase_active && !st_q.erase_abort)
        begin
            st_d.state      = S_RESET;
            st_d.chip_reset = 1'b1;
            st_d.bor_reset  = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q            <= '0;
            st_q.state      <= S_RESET;
            st_q.chip_reset <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    // outputs from flip-flops
    assign chip_reset  = st_q.chip_reset;
    assign bor_enable  = st_q.bor_enable;
    assign bor_level   = st_q.bor_level;
    assign erase_abort = st_q.erase_abort;
    assign in_sleep    = st_q.in_sleep;
    assign pready      = st_q.pready;
    assign prdata      = rdata_w;
    assign pslverr     = err_w;
endmodule : brown_out_reset_control

// File: inc/bor_pkg.sv
// constants and register map for the brown-out reset control
package bor_pkg;

    // apb register byte offsets
    localparam logic [11:0] CONFIG_OFFSET  = 12'h000;
    localparam logic [11:0] CONTROL_OFFSET = 12'h004;
    localparam logic [11:0] STATUS_OFFSET  = 12'h008;

    // configuration register fields
    localparam int MODE_LSB  = 0;
    localparam int LEVEL_LSB = 2;
    localparam int LOCK_BIT  = 4;
    // control register field
    localparam int SOFT_EN_BIT = 0;
    // status register fields
    localparam int ST_READY_BIT   = 0;
    localparam int ST_ACTIVE_BIT  = 1;
    localparam int ST_RESET_BIT   = 2;
    localparam int ST_ABORT_BIT   = 3;
    localparam int ST_STARTUP_BIT = 4;
    localparam int ST_LEVEL_LSB   = 5;

    // reset values
    localparam logic [1:0] MODE_RESET    = 2'h3;
    localparam logic [1:0] LEVEL_RESET   = 2'h0;
    localparam logic       SOFT_EN_RESET = 1'b0;

    // brown-out modes
    localparam logic [1:0] MODE_OFF       = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE  = 2'h1;
    localparam logic [1:0] MODE_OFF_SLEEP = 2'h2;
    localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;

    // level code that the comparator sees during bulk erase (2.45 V)
    localparam logic [1:0] LEVEL_ERASE = 2'h3;

    // brown-out filter time and clock rate
    localparam int CLOCK_MHZ         = 100;
    localparam int FILTER_TIME_NS    = 1000;
    localparam int FILTER_CYCLES_INT = (FILTER_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int FILTER_W          = 8;
    localparam logic [FILTER_W-1:0] FILTER_CYCLES = FILTER_CYCLES_INT[FILTER_W-1:0];

    // apb data width
    localparam int DATA_W = 32;

endpackage : bor_pkg

// File: inc/bor_if.sv
// link between the dip filter and the sequencer
`timescale 1ns/1ps
interface bor_filter_if;
    import bor_pkg::*;
    logic armed;   // detector enabled and ready
    logic below;   // comparator says supply under threshold
    logic trip;    // dip lasted past the filter time

    modport sequencer (output armed, output below, input trip);
    modport filter    (input armed, input below, output trip);
endinterface : bor_filter_if

// File: design/bor_dip_filter.sv
// noise filter: trips after a dip longer than the filter time
`timescale 1ns/1ps
module bor_dip_filter
    import bor_pkg::*;
(
    input  wire logic   pclk,
    input  wire logic   presetn,
    bor_filter_if.filter flt
);
    typedef struct packed {
        logic [FILTER_W-1:0] count;
        logic                trip;
    } filt_state_t;

    filt_state_t st_q;
    filt_state_t st_d;

    // count consecutive low cycles, restart on any recovery
    always_comb
    begin
        st_d = st_q;
        if (!(flt.armed && flt.below))
        begin
            st_d.count = '0;
            st_d.trip  = 1'b0;
        end
        else if (st_q.count >= FILTER_CYCLES)
        begin
            st_d.trip = 1'b1;
        end
        else
        begin
            st_d.count = st_q.count + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign flt.trip = st_q.trip;
endmodule : bor_dip_filter

// File: design/bor_apb_regs.sv
// apb slave holding mode, level and soft enable registers
`timescale 1ns/1ps
module bor_apb_regs
    import bor_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [DATA_W-1:0] status_word,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pslverr,
    output logic      [1:0]        brown_out_mode_field,
    output logic      [1:0]        brown_out_level_select,
    output logic                   brown_out_soft_enable
);
    typedef struct packed {
        logic [1:0]        mode;
        logic [1:0]        level;
        logic              locked;
        logic              soft_en;
        logic [DATA_W-1:0] rdata;
        logic              err;
    } reg_state_t;

    reg_state_t st_q;
    reg_state_t st_d;

    // decode; configuration is writable until a write sets the lock bit, then locked until reset
    always_comb
    begin
        st_d     = st_q;
        st_d.err = 1'b0;
        if (psel && !penable)
        begin
            st_d.rdata = '0;
            if (paddr == CONFIG_OFFSET)
            begin
                st_d.rdata[MODE_LSB +: 2]  = st_q.mode;
                st_d.rdata[LEVEL_LSB +: 2] = st_q.level;
                st_d.rdata[LOCK_BIT]       = st_q.locked;
                if (pwrite && !st_q.locked)
                begin
                    st_d.mode   = pwdata[MODE_LSB +: 2];
                    st_d.level  = pwdata[LEVEL_LSB +: 2];
                    st_d.locked = pwdata[LOCK_BIT];
                end
            end
            else if (paddr == CONTROL_OFFSET)
            begin
                st_d.rdata[SOFT_EN_BIT] = st_q.soft_en;
                if (pwrite)
                    st_d.soft_en = pwdata[SOFT_EN_BIT];
            end
            else if (paddr == STATUS_OFFSET)
            begin
                st_d.rdata = status_word;
            end
            else
            begin
                st_d.err = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q         <= '0;
            st_q.mode    <= MODE_RESET;
            st_q.level   <= LEVEL_RESET;
            st_q.soft_en <= SOFT_EN_RESET;
        end
        else
            st_q <= st_d;
    end

    assign prdata                 = st_q.rdata;
    assign pslverr                = st_q.err;
    assign brown_out_mode_field   = st_q.mode;
    assign brown_out_level_select = st_q.level;
    assign brown_out_soft_enable  = st_q.soft_en;
endmodule : bor_apb_regs

// File: tb/brown_out_reset_control_assertions.sv
// port checks for the brown-out reset control
`timescale 1ns/1ps
module brown_out_reset_control_assertions
    import bor_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pready,
    input wire logic       por_below_min,
    input wire logic       power_up_timer_busy,
    input wire logic       external_reset_pin_n,
    input wire logic       bor_below_threshold,
    input wire logic       bor_ready,
    input wire logic       bulk_erase_active,
    input wire logic       chip_reset,
    input wire logic       bor_enable,
    input wire logic [1:0] bor_level,
    input wire logic       erase_abort
);
    logic [7:0] dip_q;
    logic [7:0] dip_d;
    // run length of an armed detector under threshold
    always_comb
    begin
        dip_d = 8'h00;
        if (bor_enable && bor_ready && bor_below_threshold)
            dip_d = (dip_q == 8'hFF) ? dip_q : dip_q + 8'h01;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dip_q <= 8'h00;
        else
            dip_q <= dip_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence long_dip;
        dip_q == 8'h65;
    endsequence
    chk_por_hold: assert property (por_below_min |-> ##[1:2] chip_reset)
        else $error("chip reset low with supply under power-on level");
    chk_pin_hold: assert property (!external_reset_pin_n |-> ##[1:2] chip_reset)
        else $error("chip reset low with reset pin asserted");
    chk_timer_hold: assert property (chip_reset && power_up_timer_busy |=> chip_reset)
        else $error("start-up released while timer busy");
    chk_release_cause: assert property ($fell(chip_reset) |-> !$past(por_below_min)
        && !$past(power_up_timer_busy) && $past(external_reset_pin_n))
        else $error("chip reset released while a hold was active");
    chk_dip_filter: assert property ($rose(chip_reset) && !$past(por_below_min)
        && $past(external_reset_pin_n) |-> $past(dip_q) >= 8'h64)
        else $error("brown-out reset after a short dip");
    chk_trip_reset: assert property (long_dip and !bulk_erase_active |-> ##[0:3] chip_reset)
        else $error("no chip reset after long dip");
    chk_erase_level: assert property (bulk_erase_active |=> bor_enable && bor_level == LEVEL_ERASE)
        else $error("detector not forced during erase");
    chk_trip_abort: assert property (long_dip and bulk_erase_active |-> ##[0:3] erase_abort)
        else $error("no erase abort after long dip");
    chk_abort_noreset: assert property (erase_abort |-> !chip_reset)
        else $error("chip reset during erase abort");
    chk_apb_answer: assert property (apb_setup |=> pready)
        else $error("no apb answer after setup");
endmodule : brown_out_reset_control_assertions

bind brown_out_reset_control brown_out_reset_control_assertions
    brown_out_reset_control_assertions_i (.pclk, .presetn, .psel, .penable, .pready,
    .por_below_min, .power_up_timer_busy, .external_reset_pin_n, .bor_below_threshold,
    .bor_ready, .bulk_erase_active, .chip_reset, .bor_enable, .bor_level, .erase_abort);

// File: tb/supply_monitor_model.sv
// supply comparators and detector settling model
`timescale 1ns/1ps
module supply_monitor_model (
    input  wire logic pclk,
    input  wire logic por_low,
    input  wire logic vdd_low,
    input  wire logic slow,
    input  wire logic bor_enable,
    output logic      por_below_min,
    output logic      bor_below_threshold,
    output logic      bor_ready
);
    int   cnt  = 0;
    logic junk = 1'b0;
    // detector settles some cycles after enable
    always @(posedge pclk)
    begin
        junk <= ~junk;
        cnt  <= (bor_enable === 1'b1) ? cnt + 1 : 0;
    end
    // a disabled comparator gives no useful level
    assign bor_ready           = (bor_enable === 1'b1) && cnt >= (slow ? 12 : 4);
    assign bor_below_threshold = (bor_enable === 1'b1) ? vdd_low : junk;
    assign por_below_min       = por_low;
endmodule : supply_monitor_model

// File: tb/tb_brown_out_reset_control.sv
// self-checking bench for the brown-out reset control
`timescale 1ns/1ps
module tb_brown_out_reset_control;
    import bor_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, por_low = 1, vdd_low = 0, pin_n = 1, timer = 1;
    logic        sleep_req = 0, wake_req = 0, erase = 0, slow = 0;
    logic        por_below_min, bor_below_threshold, bor_ready;
    logic        chip_reset, bor_enable, erase_abort, in_sleep;
    logic [1:0]  bor_level;
    logic [3:0]  run_t = 4'b1110, slp_t = 4'b1010;
    int          mismatches = 0, checks_done = 0;

    always #5 pclk = ~pclk;

    brown_out_reset_control brown_out_reset_control_i (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .por_below_min,
        .power_up_timer_busy(timer), .external_reset_pin_n(pin_n), .bor_below_threshold,
        .bor_ready, .sleep_req, .wake_req, .bulk_erase_active(erase), .chip_reset,
        .bor_enable, .bor_level, .erase_abort, .in_sleep);
    supply_monitor_model supply_monitor_model_i (.pclk, .por_low, .vdd_low, .slow,
        .bor_enable, .por_below_min, .bor_below_threshold, .bor_ready);

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer is taken at the rising edge where pready is sampled high
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb answer", n < 20, 1'b1);
    endtask : apb

    task automatic wait_rst(input logic v, input int lim);
        int n;
        n = 0;
        while (chip_reset !== v && n < lim)
        begin
            @(negedge pclk);
            n++;
        end
        chk("chip_reset", chip_reset, v);
    endtask : wait_rst

    task automatic req(input logic w);
        @(posedge pclk);
        if (w)
            wake_req <= 1'b1;
        else
            sleep_req <= 1'b1;
        @(posedge pclk);
        wake_req <= 1'b0;
        sleep_req <= 1'b0;
    endtask : req

    task automatic t_start();
        repeat (5) @(negedge pclk);
        chk("chip_reset", chip_reset, 1'b1);
        @(posedge pclk);
        por_low <= 1'b0;
        repeat (5) @(negedge pclk);
        chk("chip_reset", chip_reset, 1'b1);
        @(posedge pclk);
        timer <= 1'b0;
        wait_rst(1'b0, 40);
        apb(1'b0, CONFIG_OFFSET, 32'h0);
        chk("config", rd, 32'h3);
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        chk("control", rd, 32'h0);
        apb(1'b1, 12'h00C, 32'h1);
        chk("pslverr", err, 1'b1);
        @(posedge pclk);
        pin_n <= 1'b0;
        wait_rst(1'b1, 5);
        @(posedge pclk);
        pin_n <= 1'b1;
        wait_rst(1'b0, 40);
        @(posedge pclk);
        por_low <= 1'b1;
        wait_rst(1'b1, 5);
        @(posedge pclk);
        por_low <= 1'b0;
        wait_rst(1'b0, 40);
        $display("test start done");
    endtask : t_start

    task automatic t_dip();
        @(posedge pclk);
        vdd_low <= 1'b1;
        repeat (60) @(negedge pclk);
        @(posedge pclk);
        vdd_low <= 1'b0;
        repeat (5) @(negedge pclk);
        chk("short dip", chip_reset, 1'b0);
        @(posedge pclk);
        vdd_low <= 1'b1;
        repeat (90) @(negedge pclk);
        chk("early trip", chip_reset, 1'b0);
        wait_rst(1'b1, 30);
        repeat (30) @(negedge pclk);
        chk("held low vdd", chip_reset, 1'b1);
        @(posedge pclk);
        vdd_low <= 1'b0;
        wait_rst(1'b0, 40);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk("reset cause", rd[ST_RESET_BIT], 1'b1);
        $display("test dip done");
    endtask : t_dip

    task automatic t_modes();
        int n;
        apb(1'b1, CONTROL_OFFSET, 32'h1);
        slow <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, CONFIG_OFFSET, 32'(m * 5));
            repeat (20) @(negedge pclk);
            chk("bor_level", bor_level, 32'(m));
            chk("run enable", bor_enable, run_t[m]);
            chk("chip_reset", chip_reset, 1'b0);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            chk("ready status", rd[ST_READY_BIT], run_t[m]);
            req(1'b0);
            repeat (3) @(negedge pclk);
            chk("in_sleep", in_sleep, 1'b1);
            chk("sleep enable", bor_enable, slp_t[m]);
            req(1'b1);
            n = 0;
            while (in_sleep !== 1'b0 && n < 40)
            begin
                @(negedge pclk);
                n++;
            end
            chk("slow wake", n > 5, m == 2);
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_erase();
        apb(1'b1, CONFIG_OFFSET, 32'h4);
        erase <= 1'b1;
        slow <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("erase level", bor_level, 32'(LEVEL_ERASE));
        chk("erase enable", bor_enable, 1'b1);
        @(posedge pclk);
        vdd_low <= 1'b1;
        repeat (120) @(negedge pclk);
        chk("erase_abort", erase_abort, 1'b1);
        chk("chip_reset", chip_reset, 1'b0);
        @(posedge pclk);
        vdd_low <= 1'b0;
        erase <= 1'b0;
        repeat (3) @(negedge pclk);
        chk("bor_level", bor_level, 32'h1);
        chk("mode off", bor_enable, 1'b0);
        apb(1'b1, CONFIG_OFFSET, 32'h13);
        apb(1'b1, CONFIG_OFFSET, 32'h0);
        apb(1'b0, CONFIG_OFFSET, 32'h0);
        chk("locked config", rd, 32'h13);
        $display("test erase done");
    endtask : t_erase

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict

    // watchdog against a hang
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end

    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_start();
        t_dip();
        t_modes();
        t_erase();
        print_verdict();
    end
endmodule : tb_brown_out_reset_control
